/* File: bench/cfg_monitor.sv */
// assertions on the configuration register access port
`timescale 1ns/1ps
module cfg_monitor (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        sample_valid,
    input wire logic        nvm_busy,
    input wire logic [1:0]  conversion_mode_field,
    input wire logic [2:0]  cycle_time_field,
    input wire logic [1:0]  averaging_field,
    input wire logic        soft_reset_active
);
    import sensor_cfg_pkg::*;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // access steps as seen on the port
    sequence cfg_rd;
        reg_rd && reg_addr == ADDR_CONFIG;
    endsequence
    sequence cfg_wr;
        reg_wr && reg_addr == ADDR_CONFIG && !soft_reset_active;
    endsequence
    rd_spare_zero_a: assert property (cfg_rd |=> reg_rdata[1:0] == 2'h0)
        else $error("spare config bits read nonzero");
    busy_mirror_a: assert property (cfg_rd |=> reg_rdata[12] == $past(nvm_busy))
        else $error("busy bit does not mirror storage busy");
    mode_alias_a: assert property (cfg_wr |=> conversion_mode_field[0] == $past(reg_wdata[10])
        && conversion_mode_field[1] == ($past(reg_wdata[11]) && $past(reg_wdata[10])))
        else $error("mode field not decoded from write");
    field_write_a: assert property (cfg_wr |=> cycle_time_field == $past(reg_wdata[9:7])
        && averaging_field == $past(reg_wdata[6:5]))
        else $error("cycle or averaging field not taken");
    soft_hold_a: assert property (cfg_wr ##0 reg_wdata[1] |=> soft_reset_active[*8])
        else $error("self reset not held after write");
    // second read must not see the flags that the first one cleared
    done_clear_a: assert property (reg_rd && reg_addr <= ADDR_CONFIG && !sample_valid
        ##1 cfg_rd |=> !reg_rdata[13])
        else $error("done flag survived a read");
    limit_clear_a: assert property (cfg_rd ##0 !sample_valid ##1 cfg_rd
        |=> reg_rdata[4] || reg_rdata[15:14] == 2'h0)
        else $error("limit flag survived a read in alert style");
    therm_low_a: assert property (cfg_rd |=> !(reg_rdata[4] && reg_rdata[14]))
        else $error("low flag set in therm style");
endmodule : cfg_monitor

bind sensor_configuration cfg_monitor chk (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .nvm_busy(nvm_busy),
    .conversion_mode_field(conversion_mode_field), .cycle_time_field(cycle_time_field),
    .averaging_field(averaging_field), .soft_reset_active(soft_reset_active)
);

/* File: bench/host_model.sv */
// host side of the register access port
`timescale 1ns/1ps
module host_model (
    input  wire logic        mclk,
    output logic      [3:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    logic [15:0] rd_q;
    // idle lines at time zero
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    end
    // strobes stay up so that calls may run back to back
    task automatic access(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge mclk);
        #1 rd_q = reg_rdata;
    endtask : access
    // released lines show the inverse, never a held copy
    task automatic idle();
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask : idle
endmodule : host_model

/* File: bench/tb_top.sv */
// self-checking bench for the configuration register
`timescale 1ns/1ps
module tb_top;
    import sensor_cfg_pkg::*;
    localparam int SR_CYC = 20;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        reg_wr, reg_rd, soft_act, alert;
    logic        sample_valid = 1'b0, nvm_busy = 1'b0, nvm_load_valid = 1'b0;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, temp_result, sample_data = 16'h0, nvm_load_data = 16'h0;
    logic [1:0]  mode, avg;
    logic [2:0]  cyc;
    int          n_mismatch = 0, comparisons = 0, n;
    always #50 mclk = ~mclk;
    host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // limits held fixed: high 0050h, low or hysteresis FF00h
    sensor_configuration #(.SOFT_RESET_CYCLES(SR_CYC)) dut (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .high_limit(16'h0050), .low_limit(16'hFF00), .nvm_busy(nvm_busy),
        .nvm_load_valid(nvm_load_valid), .nvm_load_data(nvm_load_data),
        .conversion_mode_field(mode), .cycle_time_field(cyc), .averaging_field(avg),
        .temp_result(temp_result), .soft_reset_active(soft_act), .alert_pin(alert));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        host.access(1'b0, a, 16'h0);
        check(host.rd_q, exp);
    endtask : rd
    task automatic smp(input logic [15:0] d);
        @(negedge mclk);
        sample_valid = 1'b1;
        sample_data = d;
    endtask : smp
    // drop all strobes at one falling edge
    task automatic settle();
        host.idle();
        sample_valid = 1'b0;
        sample_data = ~sample_data;
    endtask : settle
    task automatic t_reset();
        rd(ADDR_CONFIG, CONFIG_FACTORY);
        rd(ADDR_RESULT, RESULT_RESET);
        rd(4'hF, 16'h0000);
        settle();
        check({11'h0, mode, cyc}, {11'h0, MODE_CONT, 3'h4});
        check({14'h0, avg}, 16'h0001);
    endtask : t_reset
    task automatic t_nvm();
        @(negedge mclk);
        nvm_busy = 1'b1;
        nvm_load_valid = 1'b1;
        nvm_load_data = 16'h0E20;
        @(negedge mclk);
        nvm_load_valid = 1'b0;
        rd(ADDR_CONFIG, 16'h1620);
        settle();
        nvm_busy = 1'b0;
        rd(ADDR_CONFIG, 16'h0620);
        settle();
    endtask : t_nvm
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            host.access(1'b1, ADDR_CONFIG, {4'h0, 2'(m), 10'h001});
            rd(ADDR_CONFIG, {4'h0, (m == 2) ? 2'h0 : 2'(m), 10'h000});
        end
        host.access(1'b1, ADDR_RESULT, 16'h1234);
        rd(ADDR_RESULT, RESULT_RESET);
        settle();
        // single shot takes one result, then shutdown drops the next sample
        smp(16'h0010);
        smp(16'h0020);
        settle();
        check(temp_result, 16'h0010);
        check({14'h0, mode}, {14'h0, MODE_SHUT});
    endtask : t_modes
    task automatic t_avg();
        host.access(1'b1, ADDR_CONFIG, 16'h0020);
        settle();
        for (int i = 0; i < 8; i++) smp(16'(i * 16));
        settle();
        check(temp_result, 16'h0038);
        for (int i = 0; i < 8; i++) smp(16'h0100);
        settle();
        check(temp_result, 16'h0100);
        check({15'h0, alert}, 16'h0000);
        rd(ADDR_CONFIG, 16'hA020);
        rd(ADDR_CONFIG, 16'h0020);
        settle();
        check({15'h0, alert}, 16'h0001);
    endtask : t_avg
    task automatic t_therm();
        host.access(1'b1, ADDR_CONFIG, 16'h000C);
        settle();
        smp(16'hFE00);
        settle();
        check({15'h0, alert}, 16'h0001);
        rd(ADDR_RESULT, 16'hFE00);
        rd(ADDR_CONFIG, 16'h400C);
        host.access(1'b1, ADDR_CONFIG, 16'h0010);
        settle();
        smp(16'h0100);
        settle();
        rd(ADDR_CONFIG, 16'hA010);
        rd(ADDR_CONFIG, 16'h8010);
        settle();
        smp(16'hFE00);
        settle();
        rd(ADDR_CONFIG, 16'h2010);
        settle();
    endtask : t_therm
    // second write lands inside the self reset and must be dropped
    task automatic t_soft();
        host.access(1'b1, ADDR_CONFIG, 16'h0002);
        host.access(1'b1, ADDR_CONFIG, 16'h0000);
        settle();
        for (n = 0; n < 100 && soft_act === 1'b1; n++) @(negedge mclk);
        check(16'(n), 16'(SR_CYC - 1));
        rd(ADDR_CONFIG, 16'h0620);
        settle();
    endtask : t_soft
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        t_reset();
        t_nvm();
        t_modes();
        t_avg();
        t_therm();
        t_soft();
        finish_test();
    end
    // run needs about 90 cycles; over twenty times that cuts a hang
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule : tb_top

/* File: verilog/sensor_cfg_pkg.sv */
// constants for the sensor configuration and status register
package sensor_cfg_pkg;
    // register indices on the 16-bit map
    localparam logic [3:0]  ADDR_RESULT     = 4'h0;
    localparam logic [3:0]  ADDR_CONFIG     = 4'h1;
    // configuration field positions
    localparam int          HIGH_FLAG_BIT   = 15;
    localparam int          LOW_FLAG_BIT    = 14;
    localparam int          DONE_FLAG_BIT   = 13;
    localparam int          BUSY_FLAG_BIT   = 12;
    localparam int          MODE_HI         = 11;
    localparam int          MODE_LO         = 10;
    localparam int          CYCLE_HI        = 9;
    localparam int          CYCLE_LO        = 7;
    localparam int          AVG_HI          = 6;
    localparam int          AVG_LO          = 5;
    localparam int          STYLE_BIT       = 4;
    localparam int          POL_BIT         = 3;
    localparam int          SRC_BIT         = 2;
    localparam int          SOFT_RESET_BIT  = 1;
    // reset values
    localparam logic [15:0] CONFIG_FACTORY  = 16'h0220;
    localparam logic [15:0] RESULT_RESET    = 16'h8000;
    // only these bits are kept in non-volatile storage
    localparam logic [15:0] NVM_STORE_MASK  = 16'h07FC;
    // conversion mode codes
    localparam logic [1:0]  MODE_CONT       = 2'h0;
    localparam logic [1:0]  MODE_SHUT       = 2'h1;
    localparam logic [1:0]  MODE_CONT_ALIAS = 2'h2;
    localparam logic [1:0]  MODE_SINGLE     = 2'h3;
    // self reset timing
    localparam int          SOFT_RESET_US   = 2000;
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          SOFT_RESET_CYC  = SOFT_RESET_US * 1000 / CLK_PERIOD_NS;
endpackage : sensor_cfg_pkg

/* File: verilog/sensor_configuration.sv */
// configuration and status register with averaging and alert pin logic
`timescale 1ns/1ps
module sensor_configuration #(
    parameter int SOFT_RESET_CYCLES = sensor_cfg_pkg::SOFT_RESET_CYC
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        sample_valid,
    input  wire logic [15:0] sample_data,
    input  wire logic [15:0] high_limit,
    input  wire logic [15:0] low_limit,
    input  wire logic        nvm_busy,
    input  wire logic        nvm_load_valid,
    input  wire logic [15:0] nvm_load_data,
    output logic      [1:0]  conversion_mode_field,
    output logic      [2:0]  cycle_time_field,
    output logic      [1:0]  averaging_field,
    output logic      [15:0] temp_result,
    output logic             soft_reset_active,
    output logic             alert_pin
);
    import sensor_cfg_pkg::*;

    // elaboration check; the self reset counter is 24 bits wide
    if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 16777215) begin : g_bad_cycles
        $error("SOFT_RESET_CYCLES out of range");
    end

    // configuration and flag state
    logic        high_flag_r, high_flag_nxt;
    logic        low_flag_r, low_flag_nxt;
    logic        done_flag_r, done_flag_nxt;
    logic [1:0]  mode_r, mode_nxt;
    logic [2:0]  cycle_r, cycle_nxt;
    logic [1:0]  avg_r, avg_nxt;
    logic        style_r, style_nxt;
    logic        pol_r, pol_nxt;
    logic        src_r, src_nxt;
    logic [15:0] image_r, image_nxt;
    logic [23:0] srst_cnt_r, srst_cnt_nxt;
    logic        srst_act_r, srst_act_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic        alert_r, alert_nxt;
    // averaging state
    logic signed [21:0] acc_r, acc_nxt;
    logic [6:0]  cnt_r, cnt_nxt;
    logic [15:0] result_r, result_nxt;
    logic        update;

    logic        cfg_wr;
    logic        cfg_rd;
    logic        res_rd;
    logic        in_srst;
    logic [15:0] cfg_view;
    logic [6:0]  block_len;
    logic [2:0]  block_shift;
    logic signed [21:0] acc_sum;
    logic signed [21:0] acc_avg;

    // access decode
    assign cfg_wr  = reg_wr && reg_addr == ADDR_CONFIG;
    assign cfg_rd  = reg_rd && reg_addr == ADDR_CONFIG;
    assign res_rd  = reg_rd && reg_addr == ADDR_RESULT;
    assign in_srst = srst_cnt_r != 24'h000000;

    // assembled view of the configuration register
    always_comb begin
        cfg_view = 16'h0000;
        cfg_view[HIGH_FLAG_BIT]     = high_flag_r;
        cfg_view[LOW_FLAG_BIT]      = low_flag_r;
        cfg_view[DONE_FLAG_BIT]     = done_flag_r;
        cfg_view[BUSY_FLAG_BIT]     = nvm_busy;
        cfg_view[MODE_HI:MODE_LO]   = mode_r;
        cfg_view[CYCLE_HI:CYCLE_LO] = cycle_r;
        cfg_view[AVG_HI:AVG_LO]     = avg_r;
        cfg_view[STYLE_BIT]         = style_r;
        cfg_view[POL_BIT]           = pol_r;
        cfg_view[SRC_BIT]           = src_r;
    end

    // block length and divide shift per averaging code
    always_comb begin
        unique case (avg_r)
            2'h0: begin block_len = 7'd1;  block_shift = 3'd0; end
            2'h1: begin block_len = 7'd8;  block_shift = 3'd3; end
            2'h2: begin block_len = 7'd32; block_shift = 3'd5; end
            2'h3: begin block_len = 7'd64; block_shift = 3'd6; end
        endcase
    end

    // accumulate a fresh block, divide by shift, then start over
    always_comb begin
        acc_nxt    = acc_r;
        cnt_nxt    = cnt_r;
        result_nxt = result_r;
        update     = 1'b0;
        acc_sum    = acc_r + 22'(signed'(sample_data));
        acc_avg    = acc_sum >>> block_shift;
        if (in_srst || cfg_wr || mode_r == MODE_SHUT) begin
            // a settings change mid-block would mix two averaging depths
            acc_nxt = 22'sd0;
            cnt_nxt = 7'd0;
        end else if (sample_valid) begin
            if (cnt_r == block_len - 7'd1) begin
                result_nxt = acc_avg[15:0];
                acc_nxt    = 22'sd0;
                cnt_nxt    = 7'd0;
                update     = 1'b1;
            end else begin
                acc_nxt = acc_sum;
                cnt_nxt = cnt_r + 7'd1;
            end
        end
    end

    // averaging registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acc_r    <= 22'sd0;
            cnt_r    <= 7'd0;
            result_r <= RESULT_RESET;
        end else begin
            acc_r    <= acc_nxt;
            cnt_r    <= cnt_nxt;
            result_r <= result_nxt;
        end
    end

    // configuration fields and the stored image
    always_comb begin
        mode_nxt  = mode_r;
        cycle_nxt = cycle_r;
        avg_nxt   = avg_r;
        style_nxt = style_r;
        pol_nxt   = pol_r;
        src_nxt   = src_r;
        image_nxt = image_r;
        // single shot falls back to shutdown once its result lands
        if (update && mode_r == MODE_SINGLE) begin
            mode_nxt = MODE_SHUT;
        end
        // power-up or storage load refreshes the image
        if (nvm_load_valid) begin
            image_nxt = nvm_load_data & NVM_STORE_MASK;
        end
        // writes during the self reset are dropped, not queued
        if (cfg_wr && !in_srst) begin
            mode_nxt  = reg_wdata[MODE_HI:MODE_LO] == MODE_CONT_ALIAS ?
                        MODE_CONT : reg_wdata[MODE_HI:MODE_LO];
            cycle_nxt = reg_wdata[CYCLE_HI:CYCLE_LO];
            avg_nxt   = reg_wdata[AVG_HI:AVG_LO];
            style_nxt = reg_wdata[STYLE_BIT];
            pol_nxt   = reg_wdata[POL_BIT];
            src_nxt   = reg_wdata[SRC_BIT];
        end
        // self reset and power-up load restore the stored fields
        if (in_srst || nvm_load_valid) begin
            mode_nxt  = {1'b0, image_nxt[MODE_LO]};
            cycle_nxt = image_nxt[CYCLE_HI:CYCLE_LO];
            avg_nxt   = image_nxt[AVG_HI:AVG_LO];
            style_nxt = image_nxt[STYLE_BIT];
            pol_nxt   = image_nxt[POL_BIT];
            src_nxt   = image_nxt[SRC_BIT];
        end
    end

    // field registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r  <= CONFIG_FACTORY[MODE_HI:MODE_LO];
            cycle_r <= CONFIG_FACTORY[CYCLE_HI:CYCLE_LO];
            avg_r   <= CONFIG_FACTORY[AVG_HI:AVG_LO];
            style_r <= CONFIG_FACTORY[STYLE_BIT];
            pol_r   <= CONFIG_FACTORY[POL_BIT];
            src_r   <= CONFIG_FACTORY[SRC_BIT];
            image_r <= CONFIG_FACTORY;
        end else begin
            mode_r  <= mode_nxt;
            cycle_r <= cycle_nxt;
            avg_r   <= avg_nxt;
            style_r <= style_nxt;
            pol_r   <= pol_nxt;
            src_r   <= src_nxt;
            image_r <= image_nxt;
        end
    end

    // self reset counter; the active flag is a flop of its own so the pin never glitches
    always_comb begin
        srst_cnt_nxt = in_srst ? srst_cnt_r - 24'h000001 : srst_cnt_r;
        // a write of 1 to the reset bit starts the count
        if (cfg_wr && !in_srst && reg_wdata[SOFT_RESET_BIT]) begin
            srst_cnt_nxt = 24'(SOFT_RESET_CYCLES);
        end
        srst_act_nxt = srst_cnt_nxt != 24'h000000;
    end

    // self reset registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            srst_cnt_r <= 24'h000000;
            srst_act_r <= 1'b0;
        end else begin
            srst_cnt_r <= srst_cnt_nxt;
            srst_act_r <= srst_act_nxt;
        end
    end

    // limit compares on the value about to be stored
    logic        above_high;
    logic        below_low;
    assign above_high = $signed(result_nxt) > $signed(high_limit);
    assign below_low  = $signed(result_nxt) < $signed(low_limit);

    // status flags; read clears come first so that a same-cycle set wins
    always_comb begin
        high_flag_nxt = high_flag_r;
        low_flag_nxt  = low_flag_r;
        done_flag_nxt = done_flag_r;
        if (cfg_rd || res_rd) begin
            done_flag_nxt = 1'b0;
        end
        if (cfg_rd && !style_r) begin
            high_flag_nxt = 1'b0;
            low_flag_nxt  = 1'b0;
        end
        if (update) begin
            done_flag_nxt = 1'b1;
            if (style_r) begin
                // therm style: hysteresis clears, reads do not
                if (above_high) begin
                    high_flag_nxt = 1'b1;
                end else if (below_low) begin
                    high_flag_nxt = 1'b0;
                end
            end else begin
                // alert style: flags stick until a configuration read
                if (above_high) begin
                    high_flag_nxt = 1'b1;
                end
                if (below_low) begin
                    low_flag_nxt = 1'b1;
                end
            end
        end
        // self reset and power-up load start from clean flags
        if (in_srst || nvm_load_valid) begin
            high_flag_nxt = 1'b0;
            low_flag_nxt  = 1'b0;
            done_flag_nxt = 1'b0;
        end
        if (style_nxt) begin
            low_flag_nxt = 1'b0;
        end
    end

    // flag registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            high_flag_r <= 1'b0;
            low_flag_r  <= 1'b0;
            done_flag_r <= 1'b0;
        end else begin
            high_flag_r <= high_flag_nxt;
            low_flag_r  <= low_flag_nxt;
            done_flag_r <= done_flag_nxt;
        end
    end

    // read data is captured before the read-side clears take effect,
    // so a configuration read returns the flags it is clearing
    always_comb begin
        rdata_nxt = rdata_r;
        if (cfg_rd) begin
            rdata_nxt = cfg_view;
        end else if (res_rd) begin
            rdata_nxt = result_r;
        end else if (reg_rd) begin
            rdata_nxt = 16'h0000; // unmapped indices read zero
        end
    end

    // read data register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // pin level from the chosen source, then polarity; built from next
    // values so the pin moves in the same cycle as the flags it shows
    always_comb begin
        alert_nxt = (src_nxt ? done_flag_nxt : (high_flag_nxt | low_flag_nxt))
                    ~^ pol_nxt;
    end

    // pin register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            alert_r <= 1'b1; // inactive for active-low factory polarity
        end else begin
            alert_r <= alert_nxt;
        end
    end

    // outputs straight from their flops
    assign reg_rdata             = rdata_r;
    assign conversion_mode_field = mode_r;
    assign cycle_time_field      = cycle_r;
    assign averaging_field       = avg_r;
    assign temp_result           = result_r;
    assign soft_reset_active     = srst_act_r;
    assign alert_pin             = alert_r;

endmodule : sensor_configuration
